// [common/pulse_div_pkg.sv]
// Package with register map, field layouts and constants of the pulse divider output.
package pulse_div_pkg;
	localparam logic [7:0] ADDR_ZERO_ANGLE = 8'h07;
	localparam logic [7:0] ADDR_POLE_PAIRS = 8'h08;
	localparam logic [7:0] ADDR_SOURCE_SEL = 8'h09;
	localparam logic [7:0] ADDR_PHASE_ORDER = 8'h06;
	localparam logic [7:0] ADDR_DIV_COUNT = 8'h12;
	localparam logic [7:0] ADDR_INDEX_POL = 8'h2a;
	localparam logic [7:0] ADDR_REV_COUNTS = 8'h20;
	localparam logic [7:0] ADDR_FIXED_STEP = 8'h21;
	localparam logic [31:0] RST_ZERO_ANGLE = 32'h0000_5ff7;
	localparam logic [31:0] RST_POLE_PAIRS = 32'h0000_0001;
	localparam logic [1:0] RST_SOURCE_SEL = 2'h0;
	localparam logic RST_PHASE_ORDER = 1'b0;
	localparam logic [31:0] RST_DIV_COUNT = 32'h0000_09c4;
	localparam logic RST_INDEX_POL = 1'b1;
	localparam logic [31:0] RST_REV_COUNTS = 32'h0002_0000;
	localparam logic [31:0] RST_FIXED_STEP = 32'h0000_0100;
	localparam int CLOCK_HZ = 10_000_000;
	localparam int FIXED_PERIOD_NS = 10_000;
	localparam int FIXED_CYCLES = FIXED_PERIOD_NS / (1_000_000_000 / CLOCK_HZ);
	localparam int MAX_RATE_NS = 1_000;
	localparam int MIN_EDGE_CYCLES = (MAX_RATE_NS / 4 + 99) / 100;

	typedef enum logic [1:0] {
		SRC_ENCODER = 2'b00,
		SRC_COMMAND = 2'b01,
		SRC_FIXED = 2'b10,
		SRC_VIRTUAL = 2'b11
	} source_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} bus_req_t;

	typedef struct packed {
		logic quadA;
		logic quadB;
		logic index;
	} quad_out_t;
endpackage

// [rtl/phase_accum.sv]
// Position-to-quarter-step divider: scales source counts to output steps.
`timescale 1ns/100ps
module phase_accum
	import pulse_div_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] divCount,
	input wire logic [WIDTH-1:0] revCounts,
	input wire logic countUp,
	input wire logic countDown,
	input wire logic clear,
	output logic stepUp,
	output logic stepDown
);
	logic [WIDTH+1:0] acc;
	logic [WIDTH+1:0] quarters;
	logic [WIDTH+1:0] sum;
	logic [WIDTH+1:0] diff;

	// Four output edges per divided pulse, so the output resolution is four times the count.
	assign quarters = {divCount, 2'b00};
	assign sum = acc + quarters;
	assign diff = acc - quarters;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc <= '0;
			stepUp <= 1'b0;
			stepDown <= 1'b0;
		end else if (clear) begin
			acc <= '0;
			stepUp <= 1'b0;
			stepDown <= 1'b0;
		end else begin
			stepUp <= 1'b0;
			stepDown <= 1'b0;
			if (countUp && !countDown) begin
				if (sum >= {2'b00, revCounts}) begin
					acc <= sum - {2'b00, revCounts};
					stepUp <= 1'b1;
				end else begin
					acc <= sum;
				end
			end else if (countDown && !countUp) begin
				if (acc < quarters) begin
					acc <= diff + {2'b00, revCounts};
					stepDown <= 1'b1;
				end else begin
					acc <= diff;
				end
			end
		end
	end
endmodule

// [rtl/quad_encoder.sv]
// Quadrature state generator driven by single step pulses.
`timescale 1ns/100ps
module quad_encoder
	import pulse_div_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic stepUp,
	input wire logic stepDown,
	input wire logic swap,
	output logic quadA,
	output logic quadB,
	output logic [1:0] phase
);
	// With swap low, phases 0 to 3 give A,B of 00,10,11,01, so A leads B counting up; swap exchanges A and B.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 2'h0;
		end else if (stepUp && !stepDown) begin
			phase <= phase + 2'h1;
		end else if (stepDown && !stepUp) begin
			phase <= phase - 2'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			quadA <= 1'b0;
			quadB <= 1'b0;
		end else begin
			quadA <= swap ? phase[1] : (phase[1] ^ phase[0]);
			quadB <= swap ? (phase[1] ^ phase[0]) : phase[1];
		end
	end
endmodule

// [rtl/encoder_pulse_divider_output.sv]
// Top of the quadrature pulse divider output with source select and index pulse.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module encoder_pulse_divider_output
	import pulse_div_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int FIXED_DIV = FIXED_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic write,
	input wire logic read,
	output logic [31:0] rdata,
	input wire logic encUp,
	input wire logic encDown,
	input wire logic [WIDTH-1:0] encAngle,
	input wire logic cmdA,
	input wire logic cmdB,
	input wire logic cmdZ,
	input wire logic virtUp,
	input wire logic virtDown,
	input wire logic virtZero,
	output logic quadADiffOut,
	output logic quadBDiffOut,
	output logic indexDiffOut,
	output logic indexOpenCollectorOut
);
	bus_req_t req;
	quad_out_t outs;
	logic [31:0] polePairs;
	source_t source;
	logic phaseOrder;
	logic [WIDTH-1:0] divCount;
	logic [WIDTH-1:0] revCounts;
	logic [WIDTH-1:0] fixedStep;
	logic indexPolarity;
	logic [31:0] zeroAngle;
	logic [15:0] fixedTimer;
	logic fixedTick;
	logic [WIDTH-1:0] fixedPos;
	logic srcUp;
	logic srcDown;
	logic srcZero;
	logic stepUp;
	logic stepDown;
	logic divA;
	logic divB;
	logic [1:0] divPhase;
	logic cmdAq;
	logic cmdBq;
	logic cmdZq;
	logic [15:0] edgeTimer;
	logic [15:0] edgeWidth;
	logic [15:0] indexTimer;
	logic indexActive;
	logic zeroPending;
	logic anyStep;

	assign req = '{addr: addr, wdata: wdata, write: write, read: read};

	function automatic logic [31:0] regValue(input logic [7:0] a);
		case (a)
			ADDR_ZERO_ANGLE: regValue = zeroAngle;
			ADDR_POLE_PAIRS: regValue = polePairs;
			ADDR_SOURCE_SEL: regValue = {30'h0, source};
			ADDR_PHASE_ORDER: regValue = {31'h0, phaseOrder};
			ADDR_DIV_COUNT: regValue = 32'(divCount);
			ADDR_INDEX_POL: regValue = {31'h0, indexPolarity};
			ADDR_REV_COUNTS: regValue = 32'(revCounts);
			ADDR_FIXED_STEP: regValue = 32'(fixedStep);
			default: regValue = 32'h0000_0000;
		endcase
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			polePairs <= RST_POLE_PAIRS;
			source <= SRC_ENCODER;
			phaseOrder <= RST_PHASE_ORDER;
			divCount <= WIDTH'(RST_DIV_COUNT);
			indexPolarity <= RST_INDEX_POL;
			revCounts <= WIDTH'(RST_REV_COUNTS);
			fixedStep <= WIDTH'(RST_FIXED_STEP);
		end else if (req.write) begin
			case (req.addr)
				ADDR_POLE_PAIRS: polePairs <= req.wdata;
				ADDR_SOURCE_SEL: source <= source_t'(req.wdata[1:0]);
				ADDR_PHASE_ORDER: phaseOrder <= req.wdata[0];
				ADDR_DIV_COUNT: divCount <= WIDTH'(req.wdata);
				ADDR_INDEX_POL: indexPolarity <= req.wdata[0];
				ADDR_REV_COUNTS: revCounts <= WIDTH'(req.wdata);
				ADDR_FIXED_STEP: fixedStep <= WIDTH'(req.wdata);
				default: polePairs <= polePairs;
			endcase
		end
	end

	// The angle is read-only; it tracks the encoder's position within a turn.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			zeroAngle <= RST_ZERO_ANGLE;
		end else begin
			zeroAngle <= 32'(encAngle);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (req.read) begin
			rdata <= regValue(req.addr);
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// Internal test source: a fixed stream of forward counts.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fixedTimer <= 16'h0000;
			fixedTick <= 1'b0;
			fixedPos <= '0;
		end else begin
			fixedTick <= 1'b0;
			if (fixedTimer >= 16'(FIXED_DIV - 1)) begin
				fixedTimer <= 16'h0000;
				fixedTick <= 1'b1;
				if (fixedPos + fixedStep >= revCounts) begin
					fixedPos <= fixedPos + fixedStep - revCounts;
				end else begin
					fixedPos <= fixedPos + fixedStep;
				end
			end else begin
				fixedTimer <= fixedTimer + 16'h0001;
			end
		end
	end

	always_comb begin
		srcUp = 1'b0;
		srcDown = 1'b0;
		srcZero = 1'b0;
		case (source)
			SRC_ENCODER: begin
				srcUp = encUp;
				srcDown = encDown;
				srcZero = (encAngle == '0) && (encUp || encDown);
			end
			SRC_FIXED: begin
				srcUp = fixedTick;
				srcZero = fixedTick && (fixedPos == '0);
			end
			SRC_VIRTUAL: begin
				srcUp = virtUp;
				srcDown = virtDown;
				srcZero = virtZero;
			end
			default: begin
				srcUp = 1'b0;
			end
		endcase
	end

	phase_accum #(
		.WIDTH(WIDTH)
	) u_accum (
		.clock(clock),
		.rst_n(rst_n),
		.divCount(divCount),
		.revCounts(revCounts),
		.countUp(srcUp),
		.countDown(srcDown),
		.clear(source == SRC_COMMAND),
		.stepUp(stepUp),
		.stepDown(stepDown)
	);

	quad_encoder u_quad (
		.clock(clock),
		.rst_n(rst_n),
		.stepUp(stepUp),
		.stepDown(stepDown),
		.swap(phaseOrder),
		.quadA(divA),
		.quadB(divB),
		.phase(divPhase)
	);

	// Command inputs reach the outputs two cycles late, so several axes stay in step.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmdAq <= 1'b0;
			cmdBq <= 1'b0;
			cmdZq <= 1'b0;
		end else begin
			cmdAq <= phaseOrder ? cmdB : cmdA;
			cmdBq <= phaseOrder ? cmdA : cmdB;
			cmdZq <= cmdZ;
		end
	end

	// Edge spacing is measured, so the pulse width follows the speed.
	assign anyStep = stepUp || stepDown;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edgeTimer <= 16'h0000;
			edgeWidth <= 16'h0002;
		end else if (anyStep) begin
			edgeTimer <= 16'h0000;
			edgeWidth <= edgeTimer + 16'h0001;
		end else if (edgeTimer != 16'hffff) begin
			edgeTimer <= edgeTimer + 16'h0001;
		end
	end

	// A zero crossing is held until the divided output steps out of its zero phase.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			zeroPending <= 1'b0;
			indexActive <= 1'b0;
			indexTimer <= 16'h0000;
		end else begin
			if (srcZero) begin
				zeroPending <= 1'b1;
			end else if (anyStep && divPhase == 2'h0 && zeroPending) begin
				zeroPending <= 1'b0;
			end
			if (anyStep && divPhase == 2'h0 && zeroPending) begin
				indexActive <= 1'b1;
				indexTimer <= edgeWidth;
			end else if (indexTimer > 16'h0001) begin
				indexTimer <= indexTimer - 16'h0001;
			end else begin
				indexActive <= 1'b0;
				indexTimer <= 16'h0000;
			end
		end
	end

	always_comb begin
		if (source == SRC_COMMAND) begin
			outs = '{quadA: cmdAq, quadB: cmdBq, index: cmdZq};
		end else begin
			outs = '{quadA: divA, quadB: divB, index: indexActive};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			quadADiffOut <= 1'b0;
			quadBDiffOut <= 1'b0;
			indexDiffOut <= RST_INDEX_POL;
			indexOpenCollectorOut <= RST_INDEX_POL;
		end else begin
			quadADiffOut <= outs.quadA;
			quadBDiffOut <= outs.quadB;
			indexDiffOut <= outs.index ^ indexPolarity;
			indexOpenCollectorOut <= outs.index ^ indexPolarity;
		end
	end
endmodule

// [verification/pulse_div_monitor.sv]
// Checker of the pulse divider output ports.
`timescale 1ns/100ps
module pulse_div_monitor
	import pulse_div_pkg::*;
#(
	parameter int FIXED_DIV = FIXED_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic write,
	input wire logic read,
	input wire logic [31:0] rdata,
	input wire logic cmdA,
	input wire logic cmdB,
	input wire logic quadADiffOut,
	input wire logic quadBDiffOut,
	input wire logic indexDiffOut,
	input wire logic indexOpenCollectorOut
);
	localparam int FIXED_SPAN = 2 * FIXED_DIV + 4;
	logic [1:0] src;
	logic order, pol, zAct;
	logic [7:0] hold;
	logic [15:0] zLen, aLen, aHigh;
	assign zAct = indexDiffOut ^ pol;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src <= RST_SOURCE_SEL;
			order <= RST_PHASE_ORDER;
			pol <= RST_INDEX_POL;
		end else if (write) begin
			if (addr == ADDR_SOURCE_SEL) src <= wdata[1:0];
			if (addr == ADDR_PHASE_ORDER) order <= wdata[0];
			if (addr == ADDR_INDEX_POL) pol <= wdata[0];
		end
	end
	// Any write restarts the settle count, so mode switches are not judged.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) hold <= 8'h00;
		else if (write) hold <= 8'h00;
		else if (hold != 8'hff) hold <= hold + 8'h01;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			zLen <= 16'h0000;
			aLen <= 16'h0000;
			aHigh <= 16'h0000;
		end else begin
			zLen <= zAct ? zLen + 16'h0001 : 16'h0000;
			aLen <= quadADiffOut ? aLen + 16'h0001 : 16'h0000;
			if (!quadADiffOut && aLen != 16'h0000) aHigh <= aLen;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_read_quiet: assert property (!$past(read) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside a read answer");
	chk_cmd_copy: assert property (src == SRC_COMMAND && hold >= 4 && !order
		|-> quadADiffOut == $past(cmdA, 2) && quadBDiffOut == $past(cmdB, 2))
		else $error("command pulses not copied");
	chk_cmd_swap: assert property (src == SRC_COMMAND && hold >= 4 && order
		|-> quadADiffOut == $past(cmdB, 2) && quadBDiffOut == $past(cmdA, 2))
		else $error("command pulses not swapped");
	chk_ab_gray: assert property (hold >= 6
		|-> !($changed(quadADiffOut) && $changed(quadBDiffOut)))
		else $error("both phases changed together");
	chk_z_pins: assert property (indexDiffOut == indexOpenCollectorOut)
		else $error("index pins disagree");
	chk_z_width: assert property (src == SRC_FIXED && hold == 8'hff
		&& $fell(zAct) |-> zLen * 2 == aHigh)
		else $error("index width not half the phase width");
	chk_fixed_rate: assert property (src == SRC_FIXED && hold == 8'hff
		|-> ##[1:FIXED_SPAN] $changed(quadADiffOut))
		else $error("fixed source stalled");
	chk_z_level: assert property ($changed(pol) |-> ##[0:3] indexDiffOut == pol)
		else $error("index idle level ignores polarity");
	cov_cmd: cover property (src == SRC_COMMAND && hold >= 4 && $changed(cmdA));
	cov_fixed: cover property (src == SRC_FIXED && $changed(quadBDiffOut));
	cov_index: cover property ($fell(zAct));
endmodule
bind encoder_pulse_divider_output pulse_div_monitor #(.FIXED_DIV(FIXED_DIV))
	pulse_div_monitor_i (.clock(clock), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .write(write), .read(read), .rdata(rdata), .cmdA(cmdA),
	.cmdB(cmdB), .quadADiffOut(quadADiffOut), .quadBDiffOut(quadBDiffOut),
	.indexDiffOut(indexDiffOut), .indexOpenCollectorOut(indexOpenCollectorOut));

// [verification/quad_counter.sv]
// Model of the upper controller counting quadrature steps and index pulses.
`timescale 1ns/100ps
module quad_counter (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic quadA,
	input wire logic quadB,
	input wire logic index,
	input wire logic polarity,
	output int position,
	output int zCount
);
	logic [1:0] idx, prevIdx;
	logic zAct, zPrev;
	assign idx = {quadB, quadA ^ quadB};
	assign zAct = index ^ polarity;
	// A jump of two states is direction-blind, so it is not counted.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			position <= 0;
			zCount <= 0;
			prevIdx <= 2'h0;
			zPrev <= 1'b0;
		end else begin
			prevIdx <= idx;
			zPrev <= zAct;
			if (idx == prevIdx + 2'h1) position <= position + 1;
			else if (idx == prevIdx - 2'h1) position <= position - 1;
			if (zAct && !zPrev) zCount <= zCount + 1;
		end
	end
endmodule

// [verification/test_encoder_pulse_divider_output.sv]
// Bench that drives registers and pulse sources and counts the outputs.
`timescale 1ns/100ps
module test_encoder_pulse_divider_output
	import pulse_div_pkg::*;
;
	logic clock = 0, rst_n = 0, write = 0, read = 0, encUp = 0, virtUp = 0;
	logic virtZero = 0, pol = 1, cmdA, cmdB, qa, qb, zd;
	logic encDown = 0, cmdZ;
	logic [1:0] cmdIdx = 2'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, encAngle = 32'h0000_5ff7;
	int position, zCount, fails = 0, samples_checked = 0, cycles = 0, p0, z0;
	assign cmdA = cmdIdx[0] ^ cmdIdx[1];
	assign cmdB = cmdIdx[1];
	assign cmdZ = cmdIdx == 2'h3;
	always #50 clock = ~clock;
	encoder_pulse_divider_output #(.FIXED_DIV(8))
		encoder_pulse_divider_output_i (.clock(clock), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
		.encUp(encUp), .encDown(encDown), .encAngle(encAngle), .cmdA(cmdA),
		.cmdB(cmdB), .cmdZ(cmdZ), .virtUp(virtUp), .virtDown(1'b0),
		.virtZero(virtZero), .quadADiffOut(qa), .quadBDiffOut(qb),
		.indexDiffOut(zd), .indexOpenCollectorOut());
	quad_counter quad_counter_i (.clock(clock), .rst_n(rst_n), .quadA(qa),
		.quadB(qb), .index(zd), .polarity(pol), .position(position),
		.zCount(zCount));
	task automatic check(input string name, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write <= 1'b1;
		@(posedge clock);
		write <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		read <= 1'b1;
		@(posedge clock);
		read <= 1'b0;
		#1 check($sformatf("register %h", a), exp, rdata);
	endtask
	// Kind 0 counts the encoder up, 1 the virtual axis, 2 steps the command
	// pulses, 3 marks the virtual zero, 4 counts the encoder down.
	task automatic bump(input int kind, input int n);
		repeat (n) begin
			@(posedge clock);
			encUp <= kind == 0;
			encDown <= kind == 4;
			virtUp <= kind == 1;
			virtZero <= kind == 3;
			cmdIdx <= cmdIdx + 2'(kind == 2);
			@(posedge clock);
			encUp <= 1'b0;
			encDown <= 1'b0;
			virtUp <= 1'b0;
			virtZero <= 1'b0;
			repeat (4) @(posedge clock);
		end
		repeat (8) @(posedge clock);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rd(ADDR_ZERO_ANGLE, RST_ZERO_ANGLE);
		rd(ADDR_SOURCE_SEL, 32'h0000_0000);
		rd(ADDR_INDEX_POL, 32'h0000_0001);
		rd(ADDR_POLE_PAIRS, RST_POLE_PAIRS);
		encAngle <= 32'h0000_0abc;
		wr(ADDR_ZERO_ANGLE, 32'h0000_1234);
		rd(ADDR_ZERO_ANGLE, 32'h0000_0abc);
		wr(ADDR_POLE_PAIRS, 32'h0000_0003);
		rd(ADDR_POLE_PAIRS, 32'h0000_0003);
		rd(8'h33, 32'h0000_0000);
		$display("register test done");
		// One output step per source count keeps expectations exact.
		wr(ADDR_DIV_COUNT, 32'h0000_0001);
		wr(ADDR_REV_COUNTS, 32'h0000_0004);
		wr(ADDR_FIXED_STEP, 32'h0000_0001);
		for (int o = 0; o < 2; o++) begin
			wr(ADDR_PHASE_ORDER, 32'(o));
			p0 = position;
			bump(0, 8);
			check("encoderCount", o ? p0 - 8 : p0 + 8, position);
			p0 = position;
			bump(4, 8);
			check("encoderReverse", o ? p0 + 8 : p0 - 8, position);
		end
		$display("encoder test done");
		wr(ADDR_SOURCE_SEL, 32'h0000_0001);
		for (int o = 0; o < 2; o++) begin
			wr(ADDR_PHASE_ORDER, 32'(o));
			p0 = position;
			z0 = zCount;
			bump(2, 8);
			check("commandCount", o ? p0 - 8 : p0 + 8, position);
			check("commandIndex", z0 + 2, zCount);
		end
		$display("command test done");
		wr(ADDR_PHASE_ORDER, 32'h0000_0000);
		wr(ADDR_SOURCE_SEL, 32'h0000_0003);
		for (int z = 0; z < 2; z++) begin
			wr(ADDR_INDEX_POL, 32'(z));
			pol <= z[0];
			repeat (4) @(posedge clock);
			p0 = position;
			z0 = zCount;
			bump(3, 1);
			bump(1, 8);
			check("virtualCount", p0 + 8, position);
			check("indexCount", z0 + 1, zCount);
		end
		$display("virtual axis test done");
		wr(ADDR_SOURCE_SEL, 32'h0000_0002);
		repeat (300) @(posedge clock);
		p0 = position;
		repeat (320) @(posedge clock);
		check("fixedRate", 1, 32'((position - p0) inside {[38:42]}));
		$display("fixed source test done");
		wrap_up();
	end
endmodule
